/* File: rtl/channel_gain_offset_regs.sv */
// Overview of operation
// RULE_01 - With gain enable set, output gain is the 5-bit code times 0.2 dB.
// RULE_02 - Offset bits 9-0 are two's complement, one count per 14-bit sample LSB.
// RULE_03 - Offset affects output only while the global offset enable is 1.
// RULE_04 - Host writes the same offset to primary and mirror of each channel.
// RULE_05 - Address 27h is channel 10 primary, 28h its offset mirror.
// RULE_06 - Address 29h is channel 11 primary, 2Ah its offset mirror.
// RULE_07 - Host writes reserved bits as zero; all fields reset to zero.
`timescale 1ns/1ps
module channel_gain_offset_regs #(
  parameter int N_CHAN = gain_offset_pkg::N_CHAN
) (
  // Clock and reset
  input  wire logic                                 i_clk,
  input  wire logic                                 i_rst_b,
  input  wire logic                                 i_clk_en,
  // APB slave
  input  wire gain_offset_pkg::apb_req_t            i_apb,
  output gain_offset_pkg::apb_rsp_t                 o_apb,
  // Channel 10 and 11 samples
  input  wire gain_offset_pkg::sample_t [N_CHAN-1:0] i_sample,
  output gain_offset_pkg::sample_t [N_CHAN-1:0]      o_sample
);

  localparam int NS = gain_offset_pkg::N_STORED;
  localparam int RW = gain_offset_pkg::REG_W;
  localparam int DW = gain_offset_pkg::DATA_W;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire logic [gain_offset_pkg::IDX_W-1:0] idx = i_apb.paddr[gain_offset_pkg::ADDR_W-1:2];
  wire logic aligned  = i_apb.paddr[1:0] == 2'h0;
  wire logic setup    = i_apb.psel & ~i_apb.penable;
  wire logic hit_ctrl = aligned & (idx == gain_offset_pkg::IDX_CONTROL);
  wire logic hit_stat = aligned & (idx == gain_offset_pkg::IDX_STATUS);

  logic [NS-1:0] hit_ent;
  genvar e;
  generate
    for (e = 0; e < NS; e++)
    begin : g_dec
      assign hit_ent[e] = aligned & (idx == gain_offset_pkg::STORED_IDX[e]);  // see RULE_05 see RULE_06
    end
  endgenerate

  wire logic mapped = |hit_ent | hit_ctrl | hit_stat;

  // Answer is prepared in setup, so the access phase completes at once
  logic          ready_q;
  logic          err_q;
  logic [DW-1:0] rdata_q;
  wire  logic    commit = ready_q & i_apb.psel & i_apb.penable;
  wire  logic    wr     = commit & i_apb.pwrite & mapped;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  // Unpacked so each entry may have its own process
  logic [RW-1:0]         store_q [NS];
  logic [1:0]            ctrl_q;

  generate
    for (e = 0; e < NS; e++)
    begin : g_reg
      wire logic [RW-1:0] merged = {i_apb.pstrb[1] ? i_apb.pwdata[15:8] : store_q[e][15:8],
                                    i_apb.pstrb[0] ? i_apb.pwdata[7:0]  : store_q[e][7:0]};
      // Reserved bits are stored as written; software keeps them zero
      always_ff @(posedge i_clk or negedge i_rst_b)
      begin
        if (!i_rst_b)
          store_q[e] <= gain_offset_pkg::REG_RESET;  // see RULE_07
        else if (i_clk_en && wr && hit_ent[e])
          store_q[e] <= merged;
      end
    end
  endgenerate

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      ctrl_q <= gain_offset_pkg::CTRL_RESET;
    else if (i_clk_en && wr && hit_ctrl && i_apb.pstrb[0])
      ctrl_q <= i_apb.pwdata[1:0];
  end

  wire logic gain_apply   = ctrl_q[gain_offset_pkg::CTRL_GAIN_BIT];
  wire logic offset_apply = ctrl_q[gain_offset_pkg::CTRL_OFFSET_BIT];

  // ----------------------------------------------------------------
  // Channel datapaths
  // ----------------------------------------------------------------
  logic [N_CHAN-1:0] mismatch;
  genvar c;
  generate
    for (c = 0; c < N_CHAN; c++)
    begin : g_chan
      localparam int P = gain_offset_pkg::ENT_FIRST_PRIMARY + c * gain_offset_pkg::ENT_STRIDE;
      wire logic [gain_offset_pkg::OFFSET_W-1:0] prim_off =
        store_q[P][gain_offset_pkg::OFFSET_LSB +: gain_offset_pkg::OFFSET_W];
      wire logic [gain_offset_pkg::OFFSET_W-1:0] mirr_off =
        store_q[P+1][gain_offset_pkg::OFFSET_LSB +: gain_offset_pkg::OFFSET_W];
      // Datapath trusts the primary copy; a differing mirror is only flagged
      assign mismatch[c] = prim_off != mirr_off;  // see RULE_04

      chan_corrector #(
        .SAMPLE_W (gain_offset_pkg::SAMPLE_W)
      ) u_corr (
        .i_clk          (i_clk),
        .i_rst_b        (i_rst_b),
        .i_clk_en       (i_clk_en),
        .i_gain_apply   (gain_apply),
        .i_offset_apply (offset_apply),
        .i_gain_code    (store_q[P][gain_offset_pkg::GAIN_LSB +: gain_offset_pkg::GAIN_W]),
        .i_offset       (prim_off),
        .i_sample       (i_sample[c]),
        .o_sample       (o_sample[c])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read mux and bus answer
  // ----------------------------------------------------------------
  logic [RW-1:0] ent_rd;
  always_comb
  begin
    ent_rd = '0;
    for (int k = 0; k < NS; k++)
      ent_rd = ent_rd | (hit_ent[k] ? store_q[k] : '0);
  end

  wire logic [DW-1:0] rd_mux = hit_ctrl ? DW'(ctrl_q)
                             : hit_stat ? DW'(mismatch)
                             : DW'(ent_rd);

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ready_q <= 1'b0;
      err_q   <= 1'b0;
      rdata_q <= '0;
    end
    else if (i_clk_en)
    begin
      ready_q <= setup;
      err_q   <= setup & ~mapped;
      rdata_q <= (setup & ~i_apb.pwrite & mapped) ? rd_mux : '0;
    end
  end

  assign o_apb.pready  = ready_q;
  assign o_apb.pslverr = err_q;
  assign o_apb.prdata  = rdata_q;

endmodule

/* File: rtl/gain_offset_pkg.sv */
package gain_offset_pkg;

  // ----------------------------------------------------------------
  // Bus and register geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;
  localparam int REG_W    = 16;
  localparam int IDX_W    = 6;
  localparam int STRB_W   = DATA_W / 8;
  localparam int N_STORED = 5;
  localparam int N_CHAN   = 2;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CH9_MIRROR   = 6'h26;
  localparam logic [IDX_W-1:0] IDX_CH10_PRIMARY = 6'h27;
  localparam logic [IDX_W-1:0] IDX_CH10_MIRROR  = 6'h28;
  localparam logic [IDX_W-1:0] IDX_CH11_PRIMARY = 6'h29;
  localparam logic [IDX_W-1:0] IDX_CH11_MIRROR  = 6'h2a;
  localparam logic [IDX_W-1:0] IDX_CONTROL      = 6'h30;
  localparam logic [IDX_W-1:0] IDX_STATUS       = 6'h31;

  // Stored entries: 0 = ch9 mirror, then primary/mirror per channel
  localparam logic [N_STORED-1:0][IDX_W-1:0] STORED_IDX =
    {IDX_CH11_MIRROR, IDX_CH11_PRIMARY, IDX_CH10_MIRROR, IDX_CH10_PRIMARY, IDX_CH9_MIRROR};
  localparam int ENT_FIRST_PRIMARY = 1;
  localparam int ENT_STRIDE        = 2;

  localparam logic [REG_W-1:0] REG_RESET = 16'h0000;
  localparam logic [1:0]       CTRL_RESET = 2'h0;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int GAIN_LSB        = 11;
  localparam int GAIN_W          = 5;
  localparam int OFFSET_LSB      = 0;
  localparam int OFFSET_W        = 10;
  localparam int CTRL_GAIN_BIT   = 0;
  localparam int CTRL_OFFSET_BIT = 1;
  localparam int SAMPLE_W        = 14;
  localparam int LUT_W           = 16;
  localparam int GAIN_FRAC       = 14;

  // Linear factor for code N: 10^(N*0.2/20), unsigned with 14 fraction bits
  localparam logic [31:0][LUT_W-1:0] GAIN_LUT = {
    16'h82ac, 16'h7fb2, 16'h7cca, 16'h79f3, 16'h772d, 16'h7476, 16'h71cf, 16'h6f38,
    16'h6cb0, 16'h6a37, 16'h67cc, 16'h656f, 16'h6320, 16'h60de, 16'h5eaa, 16'h5c82,
    16'h5a67, 16'h5858, 16'h5655, 16'h545e, 16'h5273, 16'h5092, 16'h4ebd, 16'h4cf2,
    16'h4b32, 16'h497b, 16'h47cf, 16'h462d, 16'h4494, 16'h4304, 16'h417e, 16'h4000};

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [STRB_W-1:0] pstrb;
  } apb_req_t;

  typedef struct packed {
    logic              pready;
    logic              pslverr;
    logic [DATA_W-1:0] prdata;
  } apb_rsp_t;

  typedef struct packed {
    logic                       valid;
    logic signed [SAMPLE_W-1:0] data;
  } sample_t;

endpackage

/* File: rtl/chan_corrector.sv */
`timescale 1ns/1ps
module chan_corrector #(
  parameter int SAMPLE_W = gain_offset_pkg::SAMPLE_W
) (
  // Clock and reset
  input  wire logic                                     i_clk,
  input  wire logic                                     i_rst_b,
  input  wire logic                                     i_clk_en,
  // Settings
  input  wire logic                                     i_gain_apply,
  input  wire logic                                     i_offset_apply,
  input  wire logic [gain_offset_pkg::GAIN_W-1:0]       i_gain_code,
  input  wire logic signed [gain_offset_pkg::OFFSET_W-1:0] i_offset,
  // Samples
  input  wire gain_offset_pkg::sample_t                 i_sample,
  output gain_offset_pkg::sample_t                      o_sample
);

  localparam int SUM_W  = SAMPLE_W + 1;
  localparam int PROD_W = SUM_W + gain_offset_pkg::LUT_W + 1;
  localparam logic signed [SAMPLE_W-1:0] S_MAX = {1'b0, {(SAMPLE_W-1){1'b1}}};
  localparam logic signed [SAMPLE_W-1:0] S_MIN = {1'b1, {(SAMPLE_W-1){1'b0}}};

  // ----------------------------------------------------------------
  // Offset stage
  // ----------------------------------------------------------------
  // Offset counts are 14-bit sample LSBs, so they add unshifted
  wire logic signed [SUM_W-1:0] off_ext = i_offset_apply ? SUM_W'(i_offset) : '0;  // see RULE_02 see RULE_03
  wire logic signed [SUM_W-1:0] sum     = SUM_W'(i_sample.data) + off_ext;

  logic signed [SUM_W-1:0] sum_q;
  logic                    v1_q;

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      sum_q <= '0;
      v1_q  <= 1'b0;
    end
    else if (i_clk_en)
    begin
      sum_q <= sum;
      v1_q  <= i_sample.valid;
    end
  end

  // ----------------------------------------------------------------
  // Gain stage
  // ----------------------------------------------------------------
  wire logic [gain_offset_pkg::LUT_W-1:0] factor = gain_offset_pkg::GAIN_LUT[i_gain_code];  // see RULE_01
  wire logic signed [PROD_W-1:0] prod   = PROD_W'(sum_q) * $signed({1'b0, factor});
  wire logic signed [PROD_W-1:0] scaled = i_gain_apply ? (prod >>> gain_offset_pkg::GAIN_FRAC)
                                                       : PROD_W'(sum_q);  // see RULE_01
  // Saturate rather than wrap: a wrapped sample flips sign
  wire logic over  = scaled > PROD_W'(S_MAX);
  wire logic under = scaled < PROD_W'(S_MIN);
  wire logic signed [SAMPLE_W-1:0] sat = over ? S_MAX : (under ? S_MIN : scaled[SAMPLE_W-1:0]);

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_sample <= '0;
    else if (i_clk_en)
    begin
      o_sample.valid <= v1_q;
      o_sample.data  <= sat;
    end
  end

endmodule

/* File: verification/channel_gain_offset_regs_properties.sv */
`timescale 1ns/1ps
module channel_gain_offset_regs_properties #(
  parameter int N_CHAN = 2
) (
  // Watched ports
  input  wire logic                                  i_clk,
  input  wire logic                                  i_rst_b,
  input  wire logic                                  i_clk_en,
  input  wire gain_offset_pkg::apb_req_t             i_apb,
  input  wire gain_offset_pkg::apb_rsp_t             o_apb,
  input  wire gain_offset_pkg::sample_t [N_CHAN-1:0] i_sample,
  input  wire gain_offset_pkg::sample_t [N_CHAN-1:0] o_sample
);
  // ----------------------------------------------------------------
  // Bus and datapath properties
  // ----------------------------------------------------------------
  wire setup = i_apb.psel && !i_apb.penable && i_clk_en;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  property p_zero_wait; setup |=> o_apb.pready; endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("no ready after setup");
  property p_ready_once; (o_apb.pready && i_clk_en) |=> !o_apb.pready; endproperty
  a_ready_once: assert property (p_ready_once) else $error("ready held too long");
  property p_ch10_map; (setup && i_apb.paddr inside {8'h9c, 8'ha0}) |=> !o_apb.pslverr; endproperty
  a_ch10_map: assert property (p_ch10_map) else $error("channel 10 address refused");
  property p_ch11_map; (setup && i_apb.paddr inside {8'ha4, 8'ha8}) |=> !o_apb.pslverr; endproperty
  a_ch11_map: assert property (p_ch11_map) else $error("channel 11 address refused");
  property p_misalign; (setup && i_apb.paddr[1:0] != 2'h0) |=> o_apb.pslverr && o_apb.prdata == '0; endproperty
  a_misalign: assert property (p_misalign) else $error("misaligned access accepted");
  property p_reset_clear; $rose(i_rst_b) |-> o_apb == '0 && o_sample == '0; endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("outputs not clear after reset");
  // Clock enable must stay high across the pipe or the count slips
  property p_latency; (i_rst_b && i_sample[0].valid && i_clk_en) ##1 i_clk_en |=> o_sample[0].valid; endproperty
  a_latency: assert property (p_latency) else $error("sample lost in pipe");
endmodule

bind channel_gain_offset_regs channel_gain_offset_regs_properties #(.N_CHAN(N_CHAN)) i_channel_gain_offset_regs_properties (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_clk_en(i_clk_en), .i_apb(i_apb), .o_apb(o_apb),
  .i_sample(i_sample), .o_sample(o_sample));

/* File: verification/test_channel_gain_offset_regs.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_channel_gain_offset_regs;
  logic                           i_clk;
  logic                           i_rst_b;
  logic                           clk_en;
  gain_offset_pkg::apb_req_t      req;
  gain_offset_pkg::apb_rsp_t      rsp;
  gain_offset_pkg::sample_t [1:0] smp_in;
  gain_offset_pkg::sample_t [1:0] smp_out;
  int                             err_count;
  int                             cmp_count;
  logic [31:0]                    rd;
  logic                           er;
  logic [7:0]                     addr_tbl [5] = '{8'h98, 8'h9c, 8'ha0, 8'ha4, 8'ha8};
  // Primary and mirror offsets match, reserved bits zero
  logic [15:0]                    val_tbl  [5] = '{16'h0155, 16'hab21, 16'h0321, 16'h5a7e, 16'h027e};

  channel_gain_offset_regs i_channel_gain_offset_regs (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_clk_en(clk_en), .i_apb(req), .o_apb(rsp),
    .i_sample(smp_in), .o_sample(smp_out));

  initial
  begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  // ----------------------------------------------------------------
  // Bus master and reference
  // ----------------------------------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {16'h0000, d}, pstrb: 4'hf};
    @(posedge i_clk);
    req.penable <= 1'b1;
    // Answer moves only on rising edges: the falling edge shows what the next one samples
    do
    begin
      @(negedge i_clk);
    end
    while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    er = rsp.pslverr;
    @(posedge i_clk);
    req <= '0;
  endtask

  // Real arithmetic keeps the reference independent of the gain table
  function automatic int model(int x, int off, int g, logic [1:0] ctl);
    real v;
    v = x + (ctl[1] ? off : 0);
    if (ctl[0])
      v = $floor(v * 10.0 ** (g * 0.2 / 20.0));
    if (v > 8191.0)
      v = 8191.0;
    if (v < -8192.0)
      v = -8192.0;
    return int'(v);
  endfunction

  task automatic check_reset_and_map;
    for (int i = 0; i < 5; i++)
    begin
      xfer(1'b0, addr_tbl[i], 16'h0000);
      `CHK(rd, 32'h0000_0000)
      xfer(1'b1, addr_tbl[i], val_tbl[i]);
      `CHK(er, 1'b0)
    end
    for (int i = 0; i < 5; i++)
    begin
      xfer(1'b0, addr_tbl[i], 16'h0000);
      `CHK(rd, {16'h0000, val_tbl[i]})
    end
    xfer(1'b0, 8'hc4, 16'h0000);
    `CHK(rd, 32'h0000_0000)
    xfer(1'b0, 8'h9d, 16'h0000);
    `CHK(er, 1'b1)
    xfer(1'b1, 8'hac, 16'hffff);
    `CHK(er, 1'b1)
  endtask

  // Stored offsets are -223 and -386, gain codes 21 and 11
  task automatic check_datapath;
    int ins  [2] = '{1000, 8000};
    int offs [2] = '{-223, -386};
    int gns  [2] = '{21, 11};
    for (int k = 0; k < 4; k++)
    begin
      xfer(1'b1, 8'hc0, 16'(k));
      repeat (4) @(posedge i_clk);
      for (int c = 0; c < 2; c++)
        `CHK(smp_out[c].data, 14'(model(ins[c], offs[c], gns[c], 2'(k))))
    end
  endtask

  // Low enable must hold the pipe; the new sample shows once it runs again
  task automatic check_freeze;
    @(posedge i_clk);
    clk_en <= 1'b0;
    smp_in[0].data <= 14'sd2000;
    repeat (4) @(posedge i_clk);
    `CHK(smp_out[0].data, 14'(model(1000, -223, 21, 2'h3)))
    clk_en <= 1'b1;
    repeat (4) @(posedge i_clk);
    `CHK(smp_out[0].data, 14'(model(2000, -223, 21, 2'h3)))
  endtask

  task automatic check_mid_reset;
    @(posedge i_clk);
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b1;
    `CHK(smp_out[1].data, 14'h0000)
    xfer(1'b0, 8'h9c, 16'h0000);
    `CHK(rd, 32'h0000_0000)
    xfer(1'b0, 8'hc0, 16'h0000);
    `CHK(rd, 32'h0000_0000)
  endtask

  task conclude;
    $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    err_count = 0;
    cmp_count = 0;
    req = '0;
    clk_en = 1'b1;
    smp_in = '{'{1'b1, 14'sd8000}, '{1'b1, 14'sd1000}};
    i_rst_b = 1'b0;
    repeat (10) @(posedge i_clk);
    i_rst_b <= 1'b1;
    check_reset_and_map();
    check_datapath();
    check_freeze();
    check_mid_reset();
    conclude();
  end

  initial
  begin
    repeat (2000) @(posedge i_clk);
    err_count++;
    conclude();
  end
endmodule
